// >>> design/gpio_port_pkg.sv
// package: register map, field layout, drive codes and reset values
package gpio_port_pkg;

  localparam int unsigned PIN_COUNT  = 8;
  localparam int unsigned ADDR_WIDTH = 5;
  localparam int unsigned DATA_WIDTH = 8;
  localparam int unsigned CTRL_COUNT = 4;
  localparam int unsigned SEL_WIDTH  = 2;

  // register offsets
  localparam logic [4:0] OFS_OUTPUT_VALUE   = 5'h00;
  localparam logic [4:0] OFS_PIN_LEVEL      = 5'h01;
  localparam logic [4:0] OFS_DRIVE_BIT0     = 5'h02;
  localparam logic [4:0] OFS_DRIVE_BIT1     = 5'h03;
  localparam logic [4:0] OFS_DRIVE_BIT2     = 5'h04;
  localparam logic [4:0] OFS_SLEW_SELECT    = 5'h05;
  localparam logic [4:0] OFS_BYPASS         = 5'h06;
  localparam logic [4:0] OFS_BIDIR_ENABLE   = 5'h07;
  localparam logic [4:0] OFS_OUT_SEL_LOW    = 5'h08;
  localparam logic [4:0] OFS_OUT_SEL_HIGH   = 5'h09;
  localparam logic [4:0] OFS_OE_SEL_LOW     = 5'h0a;
  localparam logic [4:0] OFS_OE_SEL_HIGH    = 5'h0b;
  localparam logic [4:0] OFS_PORT_WIDE      = 5'h0f;
  localparam logic [4:0] OFS_PIN_ALIAS_BASE = 5'h10;

  // bit layout inside a config alias byte
  localparam int unsigned FLD_OUTPUT_VALUE = 0;
  localparam int unsigned FLD_DRIVE_BIT0   = 1;
  localparam int unsigned FLD_DRIVE_BIT1   = 2;
  localparam int unsigned FLD_DRIVE_BIT2   = 3;
  localparam int unsigned FLD_PIN_LEVEL    = 4;
  localparam int unsigned FLD_BIDIR_ENABLE = 5;
  localparam int unsigned FLD_SLEW_SELECT  = 6;
  localparam int unsigned FLD_BYPASS       = 7;

  // drive codes
  typedef enum logic [2:0] {
    DRIVE_ANALOG_HIZ  = 3'h0,
    DRIVE_DIGITAL_HIZ = 3'h1,
    DRIVE_PULL_UP     = 3'h2,
    DRIVE_PULL_DOWN   = 3'h3,
    DRIVE_OD_LOW      = 3'h4,
    DRIVE_OD_HIGH     = 3'h5,
    DRIVE_STRONG      = 3'h6,
    DRIVE_PULL_BOTH   = 3'h7
  } drive_code_t;

  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

endpackage

// >>> design/pin_drive_cell.sv
// one pin: drive code to pad controls, input gating
module pin_drive_cell (
  // configuration
  input  wire logic [2:0] drive_code_i,
  input  wire logic       slow_slew_i,
  input  wire logic       level_i,
  input  wire logic       hiz_request_i,
  // pad
  input  wire logic       pad_sync_i,
  output logic            pad_o,
  output logic            pad_oe_o,
  output logic            pad_res_o,
  output logic            pad_slow_o,
  output logic            in_enable_o,
  output logic            in_level_o
);
  import gpio_port_pkg::*;

  always_comb begin
    pad_o      = level_i;
    pad_oe_o   = 1'b0;
    pad_res_o  = 1'b0;
    in_enable_o = 1'b1;
    case (drive_code_t'(drive_code_i))
      DRIVE_ANALOG_HIZ: begin
        in_enable_o = 1'b0;
      end
      DRIVE_DIGITAL_HIZ: begin
        pad_oe_o = 1'b0;
      end
      DRIVE_PULL_UP: begin
        pad_oe_o  = 1'b1;
        pad_res_o = level_i;
      end
      DRIVE_PULL_DOWN: begin
        pad_oe_o  = 1'b1;
        pad_res_o = ~level_i;
      end
      DRIVE_OD_LOW: begin
        pad_oe_o = ~level_i;
      end
      DRIVE_OD_HIGH: begin
        pad_oe_o = level_i;
      end
      DRIVE_STRONG: begin
        pad_oe_o = 1'b1;
      end
      DRIVE_PULL_BOTH: begin
        pad_oe_o  = 1'b1;
        pad_res_o = 1'b1;
      end
      default: begin
        pad_oe_o = 1'b0;
      end
    endcase
    // dynamic enable overrides drive, input forced on
    if (hiz_request_i) begin
      pad_oe_o    = 1'b0;
      pad_res_o   = 1'b0;
      in_enable_o = 1'b1;
    end
    // slew only meaningful for strong edges
    pad_slow_o = slow_slew_i & pad_oe_o & ~pad_res_o;
    in_level_o = in_enable_o & pad_sync_i;
  end

endmodule

// >>> design/gpio_port_control.sv
// eight-pin port digital control with register file
// How it works
// - resistive modes: one resistive, one strong
// - open drain: one state high-Z, other strong
// - strong mode drives both levels
// - pull-both mode always resistive either way
// - slew only affects strong drive
// - slew bit zero fast, one slow
// - bypass drives pin from interconnect
// - bidir bit hands enable to interconnect
// - pin level register returns sensed levels
// - three drive registers form drive code
// - drive code encodes eight modes
// - analog high-Z disables input, reads zero, unless bidir control is high
// - data bit one high, zero low
// - pin alias read gathers bit n
// - pin alias write updates one pin
// - port-wide alias writes all pins
// - twenty interconnect connections per port
// - two select registers choose output signal
// - control high gives high-Z, input on
// - control low restores drive mode
// - two select registers choose enable signal
//
// Design decisions made here: strobed register access and the placing of the registers.
module gpio_port_control #(
  parameter int unsigned PINS = gpio_port_pkg::PIN_COUNT
) (
  // clock and reset
  input  wire logic                                  clock_i,
  input  wire logic                                  reset_n_i,
  // register port
  input  wire logic [gpio_port_pkg::ADDR_WIDTH-1:0]  reg_addr_i,
  input  wire logic [gpio_port_pkg::DATA_WIDTH-1:0]  reg_wdata_i,
  input  wire logic                                  reg_write_i,
  input  wire logic                                  reg_read_i,
  output logic      [gpio_port_pkg::DATA_WIDTH-1:0]  reg_rdata_o,
  // interconnect
  input  wire logic [PINS-1:0]                       fabric_out_i,
  input  wire logic [gpio_port_pkg::CTRL_COUNT-1:0]  fabric_oe_ctrl_i,
  output logic      [PINS-1:0]                       fabric_in_o,
  // pads
  input  wire logic [PINS-1:0]                       pad_i,
  output logic      [PINS-1:0]                       pad_o,
  output logic      [PINS-1:0]                       pad_oe_o,
  output logic      [PINS-1:0]                       pad_res_o,
  output logic      [PINS-1:0]                       pad_slow_o
);
  import gpio_port_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // state

  logic [PINS-1:0] output_value_reg;
  logic [PINS-1:0] drive_bit0_reg;
  logic [PINS-1:0] drive_bit1_reg;
  logic [PINS-1:0] drive_bit2_reg;
  logic [PINS-1:0] slew_select_reg;
  logic [PINS-1:0] bypass_reg;
  logic [PINS-1:0] bidir_enable_reg;
  logic [PINS-1:0] out_sel_low_reg;
  logic [PINS-1:0] out_sel_high_reg;
  logic [PINS-1:0] oe_sel_low_reg;
  logic [PINS-1:0] oe_sel_high_reg;
  logic [7:0]      rdata_reg;

  logic [PINS-1:0] output_value_next;
  logic [PINS-1:0] drive_bit0_next;
  logic [PINS-1:0] drive_bit1_next;
  logic [PINS-1:0] drive_bit2_next;
  logic [PINS-1:0] slew_select_next;
  logic [PINS-1:0] bypass_next;
  logic [PINS-1:0] bidir_enable_next;
  logic [PINS-1:0] out_sel_low_next;
  logic [PINS-1:0] out_sel_high_next;
  logic [PINS-1:0] oe_sel_low_next;
  logic [PINS-1:0] oe_sel_high_next;
  logic [7:0]      rdata_next;

  logic [PINS-1:0] pad_meta_reg;
  logic [PINS-1:0] pad_meta_next;
  logic [PINS-1:0] pad_sync_reg;
  logic [PINS-1:0] pad_sync_next;
  logic [PINS-1:0] pin_level;
  logic [PINS-1:0] pin_level_raw;

  ////////////////////////////////////////////////////////////////////////////
  // pad input synchroniser; first stage feeds only the second

  always_comb begin
    pad_meta_next = pad_i;
    pad_sync_next = pad_meta_reg;
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pad_meta_reg <= '0;
      pad_sync_reg <= '0;
    end else begin
      pad_meta_reg <= pad_meta_next;
      pad_sync_reg <= pad_sync_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-pin datapath

  genvar g;
  generate
    for (g = 0; g < PINS; g++) begin : g_pin
      logic [1:0] out_sel;
      logic [1:0] oe_sel;
      logic       level;
      logic       hiz_req;
      logic [2:0] code;
      // odd pins look at the upper four sources
      localparam logic [0:0] SRC_BANK = 1'(g % 2);

      assign code    = {drive_bit2_reg[g], drive_bit1_reg[g],
                        drive_bit0_reg[g]};
      assign out_sel = {out_sel_high_reg[g], out_sel_low_reg[g]};
      assign oe_sel  = {oe_sel_high_reg[g], oe_sel_low_reg[g]};
      // pin n may take any of the four interconnect outputs in its bank
      assign level   = bypass_reg[g] ?
                       fabric_out_i[{SRC_BANK, out_sel}] :
                       output_value_reg[g];
      // bidir bit 0 keeps output enabled; 1 lets control line decide
      assign hiz_req = bidir_enable_reg[g] &
                       fabric_oe_ctrl_i[oe_sel];

      pin_drive_cell u_cell (
        .drive_code_i  (code),
        .slow_slew_i   (slew_select_reg[g]),
        .level_i       (level),
        .hiz_request_i (hiz_req),
        .pad_sync_i    (pad_sync_reg[g]),
        .pad_o         (pad_o[g]),
        .pad_oe_o      (pad_oe_o[g]),
        .pad_res_o     (pad_res_o[g]),
        .pad_slow_o    (pad_slow_o[g]),
        .in_enable_o   (),
        .in_level_o    (pin_level_raw[g])
      );
    end
  endgenerate

  assign pin_level   = pin_level_raw;
  // eight inputs back into the fabric; with 8 outs and 4 ctrls = 20
  assign fabric_in_o = pin_level;

  ////////////////////////////////////////////////////////////////////////////
  // register write decode

  logic       alias_hit;
  logic [2:0] alias_pin;

  assign alias_hit = reg_addr_i[4] == OFS_PIN_ALIAS_BASE[4];
  assign alias_pin = reg_addr_i[2:0];

  always_comb begin
    output_value_next = output_value_reg;
    drive_bit0_next   = drive_bit0_reg;
    drive_bit1_next   = drive_bit1_reg;
    drive_bit2_next   = drive_bit2_reg;
    slew_select_next  = slew_select_reg;
    bypass_next       = bypass_reg;
    bidir_enable_next = bidir_enable_reg;
    out_sel_low_next  = out_sel_low_reg;
    out_sel_high_next = out_sel_high_reg;
    oe_sel_low_next   = oe_sel_low_reg;
    oe_sel_high_next  = oe_sel_high_reg;
    if (reg_write_i) begin
      if (alias_hit) begin
        // one pin, every field at once; pin level bit ignored
        output_value_next[alias_pin] = reg_wdata_i[FLD_OUTPUT_VALUE];
        drive_bit0_next[alias_pin]   = reg_wdata_i[FLD_DRIVE_BIT0];
        drive_bit1_next[alias_pin]   = reg_wdata_i[FLD_DRIVE_BIT1];
        drive_bit2_next[alias_pin]   = reg_wdata_i[FLD_DRIVE_BIT2];
        bidir_enable_next[alias_pin] = reg_wdata_i[FLD_BIDIR_ENABLE];
        slew_select_next[alias_pin]  = reg_wdata_i[FLD_SLEW_SELECT];
        bypass_next[alias_pin]       = reg_wdata_i[FLD_BYPASS];
      end else begin
        case (reg_addr_i)
          OFS_OUTPUT_VALUE: begin
            output_value_next = reg_wdata_i;
          end
          OFS_DRIVE_BIT0: begin
            drive_bit0_next = reg_wdata_i;
          end
          OFS_DRIVE_BIT1: begin
            drive_bit1_next = reg_wdata_i;
          end
          OFS_DRIVE_BIT2: begin
            drive_bit2_next = reg_wdata_i;
          end
          OFS_SLEW_SELECT: begin
            slew_select_next = reg_wdata_i;
          end
          OFS_BYPASS: begin
            bypass_next = reg_wdata_i;
          end
          OFS_BIDIR_ENABLE: begin
            bidir_enable_next = reg_wdata_i;
          end
          OFS_OUT_SEL_LOW: begin
            out_sel_low_next = reg_wdata_i;
          end
          OFS_OUT_SEL_HIGH: begin
            out_sel_high_next = reg_wdata_i;
          end
          OFS_OE_SEL_LOW: begin
            oe_sel_low_next = reg_wdata_i;
          end
          OFS_OE_SEL_HIGH: begin
            oe_sel_high_next = reg_wdata_i;
          end
          OFS_PORT_WIDE: begin
            // same byte pattern replicated over every pin
            output_value_next = {PINS{reg_wdata_i[FLD_OUTPUT_VALUE]}};
            drive_bit0_next   = {PINS{reg_wdata_i[FLD_DRIVE_BIT0]}};
            drive_bit1_next   = {PINS{reg_wdata_i[FLD_DRIVE_BIT1]}};
            drive_bit2_next   = {PINS{reg_wdata_i[FLD_DRIVE_BIT2]}};
            bidir_enable_next = {PINS{reg_wdata_i[FLD_BIDIR_ENABLE]}};
            slew_select_next  = {PINS{reg_wdata_i[FLD_SLEW_SELECT]}};
            bypass_next       = {PINS{reg_wdata_i[FLD_BYPASS]}};
          end
          default: begin
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register read decode; data one cycle after the strobe

  function automatic logic [7:0] pin_alias(input logic [2:0] n,
                                           input logic [PINS-1:0] lvl);
    logic [7:0] b;
    b = 8'h00;
    b[FLD_OUTPUT_VALUE] = output_value_reg[n];
    b[FLD_DRIVE_BIT0]   = drive_bit0_reg[n];
    b[FLD_DRIVE_BIT1]   = drive_bit1_reg[n];
    b[FLD_DRIVE_BIT2]   = drive_bit2_reg[n];
    b[FLD_PIN_LEVEL]    = lvl[n];
    b[FLD_BIDIR_ENABLE] = bidir_enable_reg[n];
    b[FLD_SLEW_SELECT]  = slew_select_reg[n];
    b[FLD_BYPASS]       = bypass_reg[n];
    return b;
  endfunction

  always_comb begin
    rdata_next = UNMAPPED_READ;
    if (reg_read_i) begin
      if (alias_hit) begin
        rdata_next = pin_alias(alias_pin, pin_level);
      end else begin
        case (reg_addr_i)
          OFS_OUTPUT_VALUE: begin
            rdata_next = output_value_reg;
          end
          OFS_PIN_LEVEL: begin
            rdata_next = pin_level;
          end
          OFS_DRIVE_BIT0: begin
            rdata_next = drive_bit0_reg;
          end
          OFS_DRIVE_BIT1: begin
            rdata_next = drive_bit1_reg;
          end
          OFS_DRIVE_BIT2: begin
            rdata_next = drive_bit2_reg;
          end
          OFS_SLEW_SELECT: begin
            rdata_next = slew_select_reg;
          end
          OFS_BYPASS: begin
            rdata_next = bypass_reg;
          end
          OFS_BIDIR_ENABLE: begin
            rdata_next = bidir_enable_reg;
          end
          OFS_OUT_SEL_LOW: begin
            rdata_next = out_sel_low_reg;
          end
          OFS_OUT_SEL_HIGH: begin
            rdata_next = out_sel_high_reg;
          end
          OFS_OE_SEL_LOW: begin
            rdata_next = oe_sel_low_reg;
          end
          OFS_OE_SEL_HIGH: begin
            rdata_next = oe_sel_high_reg;
          end
          // port-wide alias is write-only in effect; reads pin 0 view
          OFS_PORT_WIDE: begin
            rdata_next = pin_alias(3'h0, pin_level);
          end
          default: begin
            rdata_next = UNMAPPED_READ;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers; reset is analog high-Z with data low

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      output_value_reg <= RESET_BYTE;
      drive_bit0_reg   <= RESET_BYTE;
      drive_bit1_reg   <= RESET_BYTE;
      drive_bit2_reg   <= RESET_BYTE;
      slew_select_reg  <= RESET_BYTE;
      bypass_reg       <= RESET_BYTE;
      bidir_enable_reg <= RESET_BYTE;
      out_sel_low_reg  <= RESET_BYTE;
      out_sel_high_reg <= RESET_BYTE;
      oe_sel_low_reg   <= RESET_BYTE;
      oe_sel_high_reg  <= RESET_BYTE;
      rdata_reg        <= UNMAPPED_READ;
    end else begin
      output_value_reg <= output_value_next;
      drive_bit0_reg   <= drive_bit0_next;
      drive_bit1_reg   <= drive_bit1_next;
      drive_bit2_reg   <= drive_bit2_next;
      slew_select_reg  <= slew_select_next;
      bypass_reg       <= bypass_next;
      bidir_enable_reg <= bidir_enable_next;
      out_sel_low_reg  <= out_sel_low_next;
      out_sel_high_reg <= out_sel_high_next;
      oe_sel_low_reg   <= oe_sel_low_next;
      oe_sel_high_reg  <= oe_sel_high_next;
      rdata_reg        <= rdata_next;
    end
  end

  assign reg_rdata_o = rdata_reg;

endmodule

// >>> sim/gpio_port_monitor.sv
// checker: port-level properties of the port control block
module gpio_port_monitor #(
  parameter int unsigned PINS = gpio_port_pkg::PIN_COUNT
) (
  // clock and reset
  input  wire logic                                 clock_i,
  input  wire logic                                 reset_n_i,
  // register port
  input  wire logic [gpio_port_pkg::ADDR_WIDTH-1:0] reg_addr_i,
  input  wire logic [gpio_port_pkg::DATA_WIDTH-1:0] reg_wdata_i,
  input  wire logic                                 reg_write_i,
  input  wire logic                                 reg_read_i,
  input  wire logic [gpio_port_pkg::DATA_WIDTH-1:0] reg_rdata_o,
  // pins
  input  wire logic [PINS-1:0]                      fabric_in_o,
  input  wire logic [PINS-1:0]                      pad_i,
  input  wire logic [PINS-1:0]                      pad_o,
  input  wire logic [PINS-1:0]                      pad_oe_o,
  input  wire logic [PINS-1:0]                      pad_res_o,
  input  wire logic [PINS-1:0]                      pad_slow_o
);
  timeunit 1ns;
  timeprecision 100ps;
  import gpio_port_pkg::*;
  default clocking mon_clk @(posedge clock_i);
  endclocking
  default disable iff (!reset_n_i);
  ////////////////////////////////////////
  a_rdata_idle: assert property (!reg_read_i |=> reg_rdata_o == '0)
    else $error("read data not idle");
  a_level_read: assert property (
    reg_read_i && reg_addr_i == OFS_PIN_LEVEL
    |=> reg_rdata_o == $past(fabric_in_o))
    else $error("pin level read differs from sensed level");
  a_sync_level: assert property (
    (fabric_in_o & ~$past(pad_i, 2)) == '0)
    else $error("input level seen without pin high");
  a_slow_strong: assert property (
    (pad_slow_o & ~(pad_oe_o & ~pad_res_o)) == '0)
    else $error("slow edges outside strong drive");
  a_wide_strong: assert property (
    reg_write_i && reg_addr_i == OFS_PORT_WIDE
    && reg_wdata_i[5:0] == 6'h0d && !reg_wdata_i[7]
    |=> pad_oe_o == '1 && pad_o == '1 && pad_res_o == '0)
    else $error("port strong write not applied to all pins");
  a_wide_both: assert property (
    reg_write_i && reg_addr_i == OFS_PORT_WIDE && reg_wdata_i == 8'h0e
    |=> pad_oe_o == '1 && pad_res_o == '1 && pad_o == '0)
    else $error("pull both mode not resistive");
  a_wide_off: assert property (
    reg_write_i && reg_addr_i == OFS_PORT_WIDE && reg_wdata_i[3:2] == 2'h0
    |=> pad_oe_o == '0)
    else $error("high impedance code still drives");
  a_pin_alias: assert property (
    reg_write_i && reg_addr_i[4] && reg_wdata_i == 8'h4d
    |=> pad_oe_o[$past(reg_addr_i[2:0])] && pad_o[$past(reg_addr_i[2:0])])
    else $error("pin alias write did not drive its pin");
endmodule

bind gpio_port_control gpio_port_monitor #(.PINS(PINS)) i_monitor (
  .clock_i, .reset_n_i, .reg_addr_i, .reg_wdata_i, .reg_write_i,
  .reg_read_i, .reg_rdata_o, .fabric_in_o, .pad_i, .pad_o, .pad_oe_o,
  .pad_res_o, .pad_slow_o);

// >>> sim/pad_partner.sv
// external circuitry: board bias plus optional strong driver per pin
module pad_partner (
  // design pad controls
  input  wire logic [7:0] pad_o,
  input  wire logic [7:0] pad_oe_o,
  input  wire logic [7:0] pad_res_o,
  // external driver, ext_level is the board bias when not driving
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext_level,
  // sensed level
  output logic      [7:0] pad_i
);
  timeunit 1ns;
  timeprecision 100ps;
  always_comb begin
    for (int p = 0; p < 8; p++) begin
      if (pad_oe_o[p] && !pad_res_o[p])
        pad_i[p] = pad_o[p];
      else if (ext_en[p])
        pad_i[p] = ext_level[p];
      else if (pad_oe_o[p])
        pad_i[p] = pad_o[p];
      else
        pad_i[p] = ext_level[p];
    end
  end
endmodule

// >>> sim/tb_top.sv
// testbench: scenarios for the eight-pin port control block
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import gpio_port_pkg::*;
  logic       clock_i;
  logic       reset_n_i;
  logic [4:0] reg_addr_i;
  logic [7:0] reg_wdata_i;
  logic       reg_write_i;
  logic       reg_read_i;
  logic [7:0] reg_rdata_o;
  logic [7:0] fabric_out_i;
  logic [3:0] fabric_oe_ctrl_i;
  logic [7:0] fabric_in_o;
  logic [7:0] pad_i;
  logic [7:0] pad_o;
  logic [7:0] pad_oe_o;
  logic [7:0] pad_res_o;
  logic [7:0] pad_slow_o;
  logic [7:0] ext_en;
  logic [7:0] ext_level;
  int         n_mismatch;
  int         checked;
  int         cycles;
  gpio_port_control i_dut (.clock_i, .reset_n_i, .reg_addr_i, .reg_wdata_i,
    .reg_write_i, .reg_read_i, .reg_rdata_o, .fabric_out_i,
    .fabric_oe_ctrl_i, .fabric_in_o, .pad_i, .pad_o, .pad_oe_o,
    .pad_res_o, .pad_slow_o);
  pad_partner i_partner (.pad_o, .pad_oe_o, .pad_res_o, .ext_en,
    .ext_level, .pad_i);
  ////////////////////////////////////////
  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end
  // hang guard, tests need about 150 cycles
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clock_i);
    reg_write_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clock_i);
    reg_write_i <= 1'b0;
    #1;
  endtask
  task automatic rd_check(input logic [4:0] a, input logic [7:0] exp);
    @(posedge clock_i);
    reg_read_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clock_i);
    reg_read_i <= 1'b0;
    #1;
    check(reg_rdata_o, exp);
  endtask
  task automatic drive(input logic [7:0] o, input logic [3:0] c,
                       input logic [7:0] en, input logic [7:0] lvl);
    @(posedge clock_i);
    fabric_out_i <= o;
    fabric_oe_ctrl_i <= c;
    ext_en <= en;
    ext_level <= lvl;
    repeat (3) @(posedge clock_i);
    #1;
  endtask
  // expected {oe, res} per drive code and data bit
  function automatic logic [1:0] drive_exp(input logic [2:0] c,
                                           input logic d);
    case (c)
      3'h2: return {1'b1, d};
      3'h3: return {1'b1, ~d};
      3'h4: return {~d, 1'b0};
      3'h5: return {d, 1'b0};
      3'h6: return 2'b10;
      3'h7: return 2'b11;
      default: return 2'b00;
    endcase
  endfunction
  ////////////////////////////////////////
  task automatic t_reset();
    for (int a = 0; a < 17; a++)
      rd_check(a[4:0], 8'h00);
    $display("reset value test done");
  endtask
  task automatic t_codes();
    logic [1:0] e;
    for (int c = 0; c < 8; c++) begin
      for (int d = 0; d < 2; d++) begin
        wr(OFS_PORT_WIDE, {4'h0, c[2:0], d[0]});
        e = drive_exp(c[2:0], d[0]);
        check(pad_oe_o, {8{e[1]}});
        check(pad_res_o & pad_oe_o, {8{e[1] & e[0]}});
        check(pad_o & pad_oe_o, {8{e[1] & d[0]}});
      end
    end
    $display("drive code test done");
  endtask
  task automatic t_level();
    wr(OFS_PORT_WIDE, 8'h05);
    drive(8'h00, 4'h0, 8'h00, 8'h00);
    rd_check(OFS_PIN_LEVEL, 8'hff);
    drive(8'h00, 4'h0, 8'hff, 8'ha5);
    rd_check(OFS_PIN_LEVEL, 8'ha5);
    check(fabric_in_o, 8'ha5);
    wr(OFS_PIN_LEVEL, 8'h00);
    rd_check(OFS_PIN_LEVEL, 8'ha5);
    wr(OFS_PORT_WIDE, 8'h01);
    rd_check(OFS_PIN_LEVEL, 8'h00);
    check(fabric_in_o, 8'h00);
    drive(8'h00, 4'h0, 8'h00, 8'h00);
    $display("pin level test done");
  endtask
  task automatic t_alias();
    wr(OFS_PORT_WIDE, 8'h00);
    wr(OFS_PIN_ALIAS_BASE + 5'h03, 8'h4d);
    check(pad_oe_o, 8'h08);
    check(pad_slow_o, 8'h08);
    rd_check(OFS_DRIVE_BIT1, 8'h08);
    rd_check(OFS_SLEW_SELECT, 8'h08);
    rd_check(OFS_PIN_ALIAS_BASE + 5'h03, 8'h5d);
    wr(OFS_PORT_WIDE, 8'h4f);
    check(pad_slow_o, 8'h00);
    $display("alias test done");
  endtask
  task automatic t_bypass();
    wr(OFS_PORT_WIDE, 8'h8c);
    drive(8'h01, 4'h0, 8'h00, 8'h00);
    check(pad_o, 8'h55);
    wr(OFS_OUT_SEL_HIGH, 8'hff);
    drive(8'h40, 4'h0, 8'h00, 8'h00);
    check(pad_o, 8'haa);
    wr(OFS_OUT_SEL_LOW, 8'hff);
    drive(8'h08, 4'h0, 8'h00, 8'h00);
    check(pad_o, 8'h55);
    $display("bypass test done");
  endtask
  task automatic t_bidir();
    wr(OFS_PORT_WIDE, 8'h00);
    wr(OFS_DRIVE_BIT1, 8'hff);
    wr(OFS_DRIVE_BIT2, 8'hff);
    check(pad_oe_o, 8'hff);
    wr(OFS_BIDIR_ENABLE, 8'hff);
    drive(8'h00, 4'h1, 8'h00, 8'h00);
    check(pad_oe_o, 8'h00);
    wr(OFS_OE_SEL_LOW, 8'hf0);
    check(pad_oe_o, 8'hf0);
    wr(OFS_OE_SEL_HIGH, 8'hcc);
    check(pad_oe_o, 8'hfc);
    drive(8'h00, 4'h8, 8'h00, 8'h00);
    check(pad_oe_o, 8'h3f);
    wr(OFS_BIDIR_ENABLE, 8'h00);
    check(pad_oe_o, 8'hff);
    $display("bidir test done");
  endtask
  ////////////////////////////////////////
  initial begin
    reset_n_i = 1'b0;
    reg_addr_i = 5'h00;
    reg_wdata_i = 8'h00;
    reg_write_i = 1'b0;
    reg_read_i = 1'b0;
    fabric_out_i = 8'h00;
    fabric_oe_ctrl_i = 4'h0;
    ext_en = 8'h00;
    ext_level = 8'h00;
    repeat (6) @(posedge clock_i);
    reset_n_i <= 1'b1;
    t_reset();
    t_codes();
    t_level();
    t_alias();
    t_bypass();
    t_bidir();
    finish_test();
  end
endmodule
